// ==== src/hdc_pkg.sv ====
// Constants, field positions and types for the host adapter DMA channel.
// What this block does
// - Channel is idle with no request pending; address, count, command and mode are written only while idle.
// - Each completed transfer steps the current address by one, up or down.
// - Current address is read as two successive bytes at one offset.
// - Autoinitialize reloads current address from base only after end-of-process.
// - Base address write loads base and current together, two bytes, idle only.
// - The channel performs one transfer more than the programmed word count.
// - Word count decrements per transfer; terminal count when it wraps zero to FFFF.
// - Without autoinitialize, the word count is left at FFFF after terminal count.
// - Autoinitialize restores count from base; base count written with current count.
// - Command register is cleared by reset and by a master clear write.
// - Command bit 7 sets acknowledge polarity; one is active high, reset low.
// - Command bit 6 sets request polarity; one is active low, reset high.
// - Command bit 5 selects extended write, one extra cycle per transfer.
// - Command bit 3 selects compressed timing, one cycle shorter per transfer.
// - Command bit 2 set disables transfers; clear enables them.
// - Command bit 1 is ignored.
// - Status bit 0 set on terminal count or end-of-process; bit 4 shows request.
// - Mask sets on end-of-process unless autoinitialize is enabled.
package hdc_pkg;
	localparam logic [5:0] OFS_ADDR = 6'h00;
	localparam logic [5:0] OFS_COUNT = 6'h01;
	localparam logic [5:0] OFS_CMD = 6'h08;
	localparam logic [5:0] OFS_REQ = 6'h09;
	localparam logic [5:0] OFS_MASK = 6'h0A;
	localparam logic [5:0] OFS_MODE = 6'h0B;
	localparam logic [5:0] OFS_CLRPTR = 6'h0C;
	localparam logic [5:0] OFS_MCLR = 6'h0D;
	localparam logic [5:0] OFS_MASKCLR = 6'h0E;
	localparam logic [5:0] OFS_MASKBIT = 6'h0F;
	localparam logic [5:0] OFS_UPPER = 6'h23;
	localparam int CMD_ACK_POL = 7;
	localparam int CMD_REQ_POL = 6;
	localparam int CMD_WR_STYLE = 5;
	localparam int CMD_COMPRESS = 3;
	localparam int CMD_DISABLE = 2;
	localparam logic [7:0] CMD_KEEP = 8'hEC;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam int MODE_SEL_HI = 7;
	localparam int MODE_SEL_LO = 6;
	localparam int MODE_DOWN = 5;
	localparam int MODE_AUTO = 4;
	localparam int MODE_TT_HI = 3;
	localparam int MODE_TT_LO = 2;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [1:0] SEL_SINGLE = 2'h1;
	localparam logic [1:0] SEL_BLOCK = 2'h2;
	localparam logic [1:0] TT_TO_MEM = 2'h1;
	localparam int REQ_SOFT_BIT = 2;
	localparam int MSK_SET_BIT = 2;
	localparam int MASKBIT_BIT = 0;
	localparam logic MASK_RESET = 1'h1;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	localparam logic [2:0] CYC_BASE = 3'h2;
	localparam logic [2:0] CYC_NORMAL_EXTRA = 3'h1;
	localparam logic [2:0] CYC_EXT_EXTRA = 3'h1;
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_STEP = 3'b100
	} hdc_state_t;
endpackage : hdc_pkg

// ==== src/hdc_fifo_if.sv ====
// Valid/ready carrier between the channel and its transfer FIFO.
`timescale 1ns/10ps
`default_nettype none
interface hdc_fifo_if #(parameter int WIDTH = 32);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
	modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface : hdc_fifo_if
`default_nettype wire

// ==== src/hdc_fifo.sv ====
// Synchronous FIFO holding transferred bytes with their memory address.
`timescale 1ns/10ps
`default_nettype none
module hdc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	hdc_fifo_if.fifo port // Push and pop sides.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	wire push_fire = port.push_valid && port.push_ready;
	wire pop_fire = port.pop_valid && port.pop_ready;
	assign port.push_ready = (count != (AW+1)'(DEPTH));
	assign port.pop_valid = (count != '0);
	assign port.pop_data = mem[rptr];
	always_ff @(posedge clk) begin
		if (push_fire)
			mem[wptr] <= port.push_data;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			wptr <= push_fire ? AW'(wptr + 1'b1) : wptr;
			rptr <= pop_fire ? AW'(rptr + 1'b1) : rptr;
			count <= (AW+1)'(count + {AW'(0), push_fire} - {AW'(0), pop_fire});
		end
	end
endmodule : hdc_fifo
`default_nettype wire

// ==== src/hdc_xfer_timer.sv ====
// Counts the clock cycles of one transfer and flags its last cycle.
`timescale 1ns/10ps
`default_nettype none
module hdc_xfer_timer (
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic start, // Pulse: first cycle of a transfer follows.
	input wire logic [2:0] len, // Cycles in the transfer, at least one.
	output logic done // High in the transfer's last cycle.
);
	logic busy;
	logic [2:0] cnt;
	assign done = busy && (cnt == 3'h0);
	always_ff @(posedge clk) begin
		if (reset) begin
			busy <= 1'b0;
			cnt <= 3'h0;
		end else if (start) begin
			busy <= 1'b1;
			cnt <= 3'(len - 3'h1);
		end else begin
			busy <= busy && !done;
			cnt <= (cnt != 3'h0) ? 3'(cnt - 3'h1) : cnt;
		end
	end
endmodule : hdc_xfer_timer
`default_nettype wire

// ==== src/hdc_dma_channel.sv ====
// Single DMA channel of the host adapter: registers, sequencer and memory side.
`timescale 1ns/10ps
`default_nettype none
module hdc_dma_channel
	import hdc_pkg::*;
(
	input wire logic clk, // System clock, 40 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic [5:0] cpu_addr, // Register offset.
	input wire logic [7:0] cpu_wdata, // Write data byte.
	input wire logic cpu_wr, // Write strobe, one cycle.
	input wire logic cpu_rd, // Read strobe, one cycle.
	output logic [7:0] cpu_rdata, // Read data, valid the cycle after cpu_rd.
	input wire logic transfer_request, // Request pin, polarity from command bit 6.
	input wire logic [7:0] scsi_data, // Byte from the protocol controller.
	input wire logic end_of_process_in, // External end-of-process, active high.
	output logic transfer_acknowledge, // Acknowledge pin, polarity from command bit 7.
	output logic terminal_count, // Pulse on terminal count.
	output logic end_of_process_out, // Pulse on terminal count or external end-of-process.
	output logic channel_active, // High while not idle.
	output logic mem_valid, // Memory write request.
	input wire logic mem_ready, // Memory accepts the write.
	output logic [23:0] mem_addr, // Memory byte address.
	output logic [7:0] mem_data // Memory write data.
);
	hdc_state_t state;
	hdc_state_t next_state;
	logic [15:0] cur_addr;
	logic [15:0] base_addr;
	logic [15:0] cur_count;
	logic [15:0] base_count;
	logic [7:0] cmd;
	logic [7:0] mode;
	logic [7:0] upper;
	logic [7:0] hold_byte;
	logic byte_hi;
	logic mask;
	logic soft_req;
	logic tc_flag;
	logic eop_seen;
	logic xfer_done;

	hdc_fifo_if #(.WIDTH(FIFO_WIDTH)) fq ();

	hdc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.port(fq.fifo)
	);

	// Register decode. Address, count, command and mode only take writes while idle.
	wire idle = (state == ST_IDLE);
	wire in_xfer = (state == ST_XFER);
	wire in_step = (state == ST_STEP);
	wire wr_addr = cpu_wr && (cpu_addr == OFS_ADDR) && idle;
	wire wr_count = cpu_wr && (cpu_addr == OFS_COUNT) && idle;
	wire wr_cmd = cpu_wr && (cpu_addr == OFS_CMD) && idle;
	wire wr_mode = cpu_wr && (cpu_addr == OFS_MODE) && idle;
	wire wr_req = cpu_wr && (cpu_addr == OFS_REQ);
	wire wr_mask = cpu_wr && (cpu_addr == OFS_MASK);
	wire wr_clrptr = cpu_wr && (cpu_addr == OFS_CLRPTR);
	wire wr_mclr = cpu_wr && (cpu_addr == OFS_MCLR);
	wire wr_maskclr = cpu_wr && (cpu_addr == OFS_MASKCLR);
	wire wr_maskbit = cpu_wr && (cpu_addr == OFS_MASKBIT);
	wire wr_upper = cpu_wr && (cpu_addr == OFS_UPPER);
	wire rd_addr = cpu_rd && (cpu_addr == OFS_ADDR);
	wire rd_count = cpu_rd && (cpu_addr == OFS_COUNT);
	wire rd_status = cpu_rd && (cpu_addr == OFS_CMD);
	wire rd_hold = cpu_rd && (cpu_addr == OFS_MCLR);
	wire byte_access = wr_addr || wr_count || rd_addr || rd_count;

	// Mode and command fields.
	wire [1:0] sel = mode[MODE_SEL_HI:MODE_SEL_LO];
	wire [1:0] ttype = mode[MODE_TT_HI:MODE_TT_LO];
	wire auto_en = mode[MODE_AUTO];
	wire count_down_addr = mode[MODE_DOWN];
	wire disabled = cmd[CMD_DISABLE];
	// Bit 6 set means the pin is active low, so the level is inverted.
	wire req_level = transfer_request ^ cmd[CMD_REQ_POL];
	// The requester keeps the pin up until acknowledged, so a plain level is enough.
	wire hw_req = req_level && !mask;
	wire pending = hw_req || soft_req;
	wire to_mem = (ttype == TT_TO_MEM);

	// Transfer length: normal timing adds a cycle, extended write adds a cycle.
	wire [2:0] len_norm = cmd[CMD_COMPRESS] ? 3'h0 : CYC_NORMAL_EXTRA;
	wire [2:0] len_ext = cmd[CMD_WR_STYLE] ? CYC_EXT_EXTRA : 3'h0;
	wire [2:0] xfer_len = 3'(CYC_BASE + len_norm + len_ext);

	// Terminal count is taken when the count leaves zero, so value plus one transfers run.
	wire tc_hit = in_step && (cur_count == WORD_ZERO);
	wire eop = tc_hit || (in_step && eop_seen);
	wire reload = eop && auto_en;
	wire go = idle && !disabled && pending && fq.push_ready;
	wire keep_going = !eop && (sel != SEL_SINGLE) && !disabled && fq.push_ready && ((sel == SEL_BLOCK) || pending);
	wire timer_start = go || (in_step && keep_going);

	hdc_xfer_timer u_timer (
		.clk(clk),
		.reset(reset),
		.start(timer_start),
		.len(xfer_len),
		.done(xfer_done)
	);

	// Sequencer.
	always_comb begin
		case (state)
			ST_IDLE: begin
				next_state = go ? ST_XFER : ST_IDLE;
			end
			ST_XFER: begin
				next_state = xfer_done ? ST_STEP : ST_XFER;
			end
			ST_STEP: begin
				next_state = keep_going ? ST_XFER : ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Address and count datapath.
	wire [15:0] stepped_addr = count_down_addr ? 16'(cur_addr - WORD_ONE) : 16'(cur_addr + WORD_ONE);
	wire [15:0] stepped_count = 16'(cur_count - WORD_ONE);
	wire [15:0] addr_wr_val = byte_hi ? {cpu_wdata, cur_addr[7:0]} : {cur_addr[15:8], cpu_wdata};
	wire [15:0] count_wr_val = byte_hi ? {cpu_wdata, cur_count[7:0]} : {cur_count[15:8], cpu_wdata};
	wire [15:0] next_cur_addr = wr_addr ? addr_wr_val :
		reload ? base_addr :
		in_step ? stepped_addr : cur_addr;
	wire [15:0] next_base_addr = wr_addr ? addr_wr_val : base_addr;
	wire [15:0] next_cur_count = wr_count ? count_wr_val :
		reload ? base_count :
		in_step ? stepped_count : cur_count;
	wire [15:0] next_base_count = wr_count ? count_wr_val : base_count;

	// Control state. Hardware events take priority over a software clear in the same cycle.
	wire next_byte_hi = (wr_clrptr || wr_mclr) ? 1'b0 : byte_access ? !byte_hi : byte_hi;
	wire [7:0] next_cmd = wr_mclr ? CMD_RESET : wr_cmd ? (cpu_wdata & CMD_KEEP) : cmd;
	wire next_mask = wr_mclr ? MASK_RESET :
		(eop && !auto_en) ? 1'b1 :
		wr_mask ? cpu_wdata[MSK_SET_BIT] :
		wr_maskbit ? cpu_wdata[MASKBIT_BIT] :
		wr_maskclr ? 1'b0 : mask;
	wire next_soft_req = wr_req ? cpu_wdata[REQ_SOFT_BIT] : (eop || wr_mclr) ? 1'b0 : soft_req;
	wire next_tc_flag = eop || (tc_flag && !rd_status && !wr_mclr);
	wire next_eop_seen = in_xfer && (eop_seen || end_of_process_in);

	// Read mux: reserved and unmapped offsets read zero.
	wire [7:0] addr_byte = byte_hi ? cur_addr[15:8] : cur_addr[7:0];
	wire [7:0] count_byte = byte_hi ? cur_count[15:8] : cur_count[7:0];
	wire [7:0] status_byte = {3'h0, pending, 3'h0, tc_flag};
	wire [7:0] rd_val = rd_addr ? addr_byte :
		rd_count ? count_byte :
		rd_status ? status_byte :
		rd_hold ? hold_byte : ZERO_BYTE;

	// The FIFO entry carries the full memory address with the byte.
	assign fq.push_valid = in_step && to_mem;
	assign fq.push_data = {upper, cur_addr, hold_byte};
	// The output stage refills whenever it is empty or being taken; memory stalls back up the FIFO.
	assign fq.pop_ready = !mem_valid || mem_ready;
	wire pop_fire = fq.pop_valid && fq.pop_ready;

	// Acknowledge is held for every cycle of a transfer; bit 7 set drives it high when active.
	wire ack_on = (next_state == ST_XFER);
	wire next_ack_pin = ack_on ~^ next_cmd[CMD_ACK_POL];

	always_ff @(posedge clk) begin
		if (reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk) begin
		cur_addr <= next_cur_addr;
		base_addr <= next_base_addr;
		cur_count <= next_cur_count;
		base_count <= next_base_count;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd <= CMD_RESET;
			mode <= MODE_RESET;
			upper <= ZERO_BYTE;
			byte_hi <= 1'b0;
			mask <= MASK_RESET;
			soft_req <= 1'b0;
			tc_flag <= 1'b0;
			eop_seen <= 1'b0;
		end else begin
			cmd <= next_cmd;
			mode <= wr_mode ? cpu_wdata : mode;
			upper <= wr_upper ? cpu_wdata : upper;
			byte_hi <= next_byte_hi;
			mask <= next_mask;
			soft_req <= next_soft_req;
			tc_flag <= next_tc_flag;
			eop_seen <= next_eop_seen;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			hold_byte <= ZERO_BYTE;
		else if (in_xfer && xfer_done)
			hold_byte <= scsi_data;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_rdata <= ZERO_BYTE;
			transfer_acknowledge <= 1'b1;
			terminal_count <= 1'b0;
			end_of_process_out <= 1'b0;
			channel_active <= 1'b0;
		end else begin
			cpu_rdata <= cpu_rd ? rd_val : cpu_rdata;
			transfer_acknowledge <= next_ack_pin;
			terminal_count <= tc_hit;
			end_of_process_out <= eop;
			channel_active <= (next_state != ST_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mem_valid <= 1'b0;
			mem_addr <= 24'h000000;
			mem_data <= ZERO_BYTE;
		end else if (fq.pop_ready) begin
			mem_valid <= fq.pop_valid;
			mem_addr <= pop_fire ? fq.pop_data[31:8] : mem_addr;
			mem_data <= pop_fire ? fq.pop_data[7:0] : mem_data;
		end
	end
endmodule : hdc_dma_channel
`default_nettype wire

// ==== verification/hdc_far_model.sv ====
// Far-side model: the requesting protocol controller and the host memory.
`timescale 1ns/10ps
`default_nettype none
module hdc_far_model (
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic want, // Bench asks for service.
	input wire logic req_low, // Request is active low.
	input wire logic ack_hi, // Acknowledge is active high.
	input wire logic stall, // Memory refuses writes.
	input wire logic transfer_acknowledge, // Acknowledge from the channel.
	input wire logic mem_valid, // Write request from the channel.
	output logic transfer_request, // Request to the channel.
	output logic [7:0] scsi_data, // Byte offered to the channel.
	output logic mem_ready, // Memory accepts the write.
	output logic [7:0] grants // Acknowledges seen so far.
);
	logic ack_on;
	logic ack_d;
	// The bench holds want for a fixed number of cycles, so in block mode the request can drop before the service ends.
	assign transfer_request = want ^ req_low;
	assign ack_on = ack_hi ? transfer_acknowledge : !transfer_acknowledge;
	assign mem_ready = !stall;
	always_ff @(posedge clk) begin
		ack_d <= ack_on && !reset;
		grants <= reset ? 8'h00 : grants + {7'h00, ack_on && !ack_d};
		// A byte that changes every cycle keeps a stale sample from passing for a fresh one.
		scsi_data <= reset ? 8'h00 : scsi_data + 8'h3B;
	end
endmodule : hdc_far_model
`default_nettype wire

// ==== verification/hdc_dma_channel_assertions.sv ====
// Port-level assertions for the DMA channel, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module hdc_dma_assert
	import hdc_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic [5:0] cpu_addr, // Register offset.
	input wire logic [7:0] cpu_wdata, // Write byte.
	input wire logic cpu_wr, // Write strobe.
	input wire logic cpu_rd, // Read strobe.
	input wire logic [7:0] cpu_rdata, // Read byte.
	input wire logic transfer_acknowledge, // Acknowledge pin.
	input wire logic terminal_count, // Terminal count pulse.
	input wire logic end_of_process_out, // End-of-process pulse.
	input wire logic channel_active, // Busy level.
	input wire logic mem_valid, // Memory request.
	input wire logic mem_ready, // Memory accept.
	input wire logic [23:0] mem_addr, // Memory address.
	input wire logic [7:0] mem_data // Memory byte.
);
	logic [7:0] cmd_sh;
	logic [2:0] ack_len;
	logic [2:0] exp_len;
	logic ack_on;
	// The command is shadowed from the bus, so a dropped or misdecoded write shows up below.
	assign ack_on = channel_active && (cmd_sh[CMD_ACK_POL] ? transfer_acknowledge : !transfer_acknowledge);
	assign exp_len = 3'h2 + {2'h0, !cmd_sh[CMD_COMPRESS]} + {2'h0, cmd_sh[CMD_WR_STYLE]};
	always_ff @(posedge clk) begin
		if (reset || (cpu_wr && cpu_addr == OFS_MCLR))
			cmd_sh <= 8'h00;
		else if (cpu_wr && cpu_addr == OFS_CMD && !channel_active)
			cmd_sh <= cpu_wdata;
	end
	always_ff @(posedge clk) begin
		ack_len <= ack_on ? ack_len + 3'h1 : 3'h0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_granted; $past(ack_on, 2); endsequence
	sequence s_stepped; !$past(ack_on); endsequence
	property p_idle_ack; !channel_active && $stable(cmd_sh[CMD_ACK_POL]) |-> transfer_acknowledge == !cmd_sh[CMD_ACK_POL]; endproperty
	property p_ack_len; $fell(ack_on) |-> ack_len == exp_len; endproperty
	property p_tc_cause; terminal_count |-> s_granted ##0 s_stepped; endproperty
	property p_tc_pulse; terminal_count |=> !terminal_count; endproperty
	property p_tc_eop; terminal_count |-> end_of_process_out; endproperty
	property p_eop_idle; end_of_process_out |-> !channel_active; endproperty
	property p_rdata; !cpu_rd |=> $stable(cpu_rdata); endproperty
	property p_disabled; cmd_sh[CMD_DISABLE] && !channel_active |=> !channel_active; endproperty
	property p_mem_hold; mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data); endproperty
	property p_mclr; cpu_wr && cpu_addr == OFS_MCLR && !channel_active |-> ##2 transfer_acknowledge; endproperty
	a_idle_ack: assert property (p_idle_ack) else $error("acknowledge active while idle");
	a_ack_len: assert property (p_ack_len) else $error("acknowledge length wrong");
	a_tc_cause: assert property (p_tc_cause) else $error("terminal count without transfer");
	a_tc_pulse: assert property (p_tc_pulse) else $error("terminal count too long");
	a_tc_eop: assert property (p_tc_eop) else $error("terminal count without end of process");
	a_eop_idle: assert property (p_eop_idle) else $error("still active after end of process");
	a_rdata: assert property (p_rdata) else $error("read data moved without read");
	a_disabled: assert property (p_disabled) else $error("started while disabled");
	a_mem_hold: assert property (p_mem_hold) else $error("memory write changed before accept");
	a_mclr: assert property (p_mclr) else $error("acknowledge polarity kept after clear");
endmodule : hdc_dma_assert
bind hdc_dma_channel hdc_dma_assert hdc_dma_assert_i (.clk(clk), .reset(reset), .cpu_addr(cpu_addr),
	.cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
	.transfer_acknowledge(transfer_acknowledge), .terminal_count(terminal_count),
	.end_of_process_out(end_of_process_out), .channel_active(channel_active), .mem_valid(mem_valid),
	.mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data));
`default_nettype wire

// ==== verification/test_host_adapter_dma_channel.sv ====
// Self-checking bench for the host adapter DMA channel.
`timescale 1ns/10ps
`default_nettype none
module test_host_adapter_dma_channel
	import hdc_pkg::*;
;
	logic clk = 1'b0, reset = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0;
	logic want = 1'b0, req_low = 1'b0, ack_hi = 1'b0, stall = 1'b0, eop_in = 1'b0;
	logic [5:0] cpu_addr = 6'h00;
	logic [7:0] cpu_wdata = 8'h00;
	logic [7:0] cpu_rdata, scsi_data, mem_data, grants, g;
	logic transfer_request, transfer_acknowledge, terminal_count, end_of_process_out;
	logic channel_active, mem_valid, mem_ready, ack_on;
	logic [23:0] mem_addr;
	logic [23:0] q[$];
	logic [15:0] w;
	logic [7:0] cmds [4] = '{8'h08, 8'h00, 8'h28, 8'hC8};
	int fail_count = 0, tests_run = 0, width;
	assign ack_on = ack_hi ? transfer_acknowledge : !transfer_acknowledge;
	hdc_dma_channel hdc_dma_channel_i (.clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .transfer_request(transfer_request),
		.scsi_data(scsi_data), .end_of_process_in(eop_in), .transfer_acknowledge(transfer_acknowledge),
		.terminal_count(terminal_count), .end_of_process_out(end_of_process_out), .channel_active(channel_active),
		.mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data));
	hdc_far_model hdc_far_model_i (.clk(clk), .reset(reset), .want(want), .req_low(req_low), .ack_hi(ack_hi),
		.stall(stall), .transfer_acknowledge(transfer_acknowledge), .mem_valid(mem_valid),
		.transfer_request(transfer_request), .scsi_data(scsi_data), .mem_ready(mem_ready), .grants(grants));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (mem_valid && mem_ready) q.push_back(mem_addr);
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge clk);
		cpu_wr = 1'b0;
		@(negedge clk);
	endtask : wr
	// Two-byte reads keep the strobe up for two edges, so both bytes share one pointer pass.
	task automatic rd(input logic [5:0] a, input int n, output logic [15:0] v);
		v = 16'h0000;
		cpu_addr = a;
		cpu_rd = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			v[8*i +: 8] = cpu_rdata;
		end
		cpu_rd = 1'b0;
		@(negedge clk);
	endtask : rd
	task automatic prog(input logic [15:0] ad, input logic [15:0] cn, input logic [7:0] md, input logic [7:0] cm);
		wr(OFS_CLRPTR, 8'h00);
		wr(OFS_ADDR, ad[7:0]);
		wr(OFS_ADDR, ad[15:8]);
		wr(OFS_COUNT, cn[7:0]);
		wr(OFS_COUNT, cn[15:8]);
		wr(OFS_MODE, md);
		wr(OFS_CMD, cm);
		wr(OFS_MASKCLR, 8'h00);
	endtask : prog
	task automatic run(input int n);
		want = 1'b1;
		repeat (n) @(negedge clk);
		want = 1'b0;
	endtask : run
	task automatic wait_q(input int n);
		for (int i = 0; i < 400 && q.size() < n; i++) @(negedge clk);
		repeat (4) @(negedge clk);
	endtask : wait_q
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (5) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		rd(OFS_CMD, 1, w);
		chk(w, 24'h000000);
		chk(transfer_acknowledge, 24'h000001);
		wr(6'h05, 8'hA5);
		rd(6'h05, 1, w);
		chk(w, 24'h000000);
		$display("test reset done");
		wr(OFS_UPPER, 8'h5A);
		prog(16'h1234, 16'h0002, 8'h44, 8'h08);
		rd(OFS_ADDR, 2, w);
		chk(w, 24'h001234);
		rd(OFS_COUNT, 2, w);
		chk(w, 24'h000002);
		run(60);
		chk(q.size(), 24'h000003);
		chk(q[2], 24'h5A1236);
		rd(OFS_COUNT, 2, w);
		chk(w, 24'h00FFFF);
		rd(OFS_ADDR, 2, w);
		chk(w, 24'h001237);
		rd(OFS_CMD, 1, w);
		chk(w, 24'h000001);
		rd(OFS_CMD, 1, w);
		chk(w, 24'h000000);
		run(30);
		chk(grants, 24'h000003);
		$display("test single transfer done");
		q.delete();
		prog(16'h1234, 16'h0001, 8'hB4, 8'h08);
		run(4);
		wait_q(2);
		chk(q[1][15:0], 24'h001233);
		rd(OFS_COUNT, 2, w);
		chk(w, 24'h000001);
		rd(OFS_ADDR, 2, w);
		chk(w, 24'h001234);
		run(4);
		wait_q(4);
		chk(q.size(), 24'h000004);
		$display("test autoinit done");
		foreach (cmds[i]) begin
			wr(OFS_MASK, 8'h04);
			req_low = cmds[i][6];
			ack_hi = cmds[i][7];
			prog(16'h0010, 16'h0000, 8'h44, cmds[i]);
			chk(transfer_acknowledge, !cmds[i][7]);
			width = 0;
			want = 1'b1;
			repeat (20) begin
				@(negedge clk);
				if (ack_on) width++;
			end
			want = 1'b0;
			chk(width, 2 + !cmds[i][3] + cmds[i][5]);
		end
		$display("test timing done");
		wr(OFS_MASK, 8'h04);
		req_low = 1'b0;
		ack_hi = 1'b0;
		prog(16'h0010, 16'h0000, 8'h44, 8'h0E);
		g = grants;
		run(20);
		chk(grants, g);
		wr(OFS_REQ, 8'h04);
		rd(OFS_CMD, 1, w);
		chk(w, 24'h000011);
		wr(OFS_REQ, 8'h00);
		wr(OFS_CMD, 8'h0A);
		run(20);
		chk(grants, g + 8'h01);
		wr(OFS_CMD, 8'h80);
		chk(transfer_acknowledge, 24'h000000);
		wr(OFS_MCLR, 8'h00);
		chk(transfer_acknowledge, 24'h000001);
		$display("test command done");
		q.delete();
		stall = 1'b1;
		prog(16'h0100, 16'h000B, 8'h44, 8'h08);
		g = grants;
		run(150);
		chk(grants, g + 8'h09);
		stall = 1'b0;
		run(150);
		wait_q(12);
		chk(q.size(), 24'h00000C);
		chk(q[11][15:0], 24'h00010B);
		$display("test buffer done");
		// An external end-of-process in mid-block must end the service early and flag it.
		q.delete();
		rd(OFS_CMD, 1, w);
		prog(16'h0200, 16'h0010, 8'h84, 8'h08);
		run(2);
		repeat (3) @(negedge clk);
		eop_in = 1'b1;
		repeat (3) @(negedge clk);
		eop_in = 1'b0;
		wait_q(17);
		rd(OFS_CMD, 1, w);
		chk(w, 24'h000001);
		rd(OFS_COUNT, 2, w);
		chk(w + q.size(), 24'h000010);
		chk(q.size() < 17, 24'h000001);
		$display("test external end done");
		end_of_test();
	end
endmodule : test_host_adapter_dma_channel
`default_nettype wire
